/* File: hdl/ssienc_pkg.sv */
package ssienc_pkg;

  // ==========================================================
  // Position and word layout
  localparam int RESOLUTION = 360;
  localparam int NEXT_POW2 = 512;
  localparam int EXCESS_OFFSET = (NEXT_POW2 - RESOLUTION) / 2;
  localparam int POS_W = 12;
  localparam int WORD_W = 16;
  // Word plus one alarm bit; the same count for every resolution
  localparam int FRAME_BITS = WORD_W + 1;
  localparam int CNT_W = 5;
  localparam logic [POS_W-1:0] RES_POS = RESOLUTION[POS_W-1:0];
  localparam logic [POS_W-1:0] EXCESS_POS = EXCESS_OFFSET[POS_W-1:0];
  localparam logic [CNT_W-1:0] FRAME_CNT = FRAME_BITS[CNT_W-1:0];

  // ==========================================================
  // Timing
  localparam int CLK_NS = 20;
  localparam int MONOFLOP_TIMEOUT_NS = 20000;
  localparam int MONOFLOP_CYC = MONOFLOP_TIMEOUT_NS / CLK_NS;
  localparam int MAX_RATE_BPS = 1500000;
  localparam int MIN_SCLK_PERIOD_NS = (1000000000 + MAX_RATE_BPS - 1) / MAX_RATE_BPS;
  localparam int SCLK_HALF_CYC = (MIN_SCLK_PERIOD_NS + 2 * CLK_NS - 1) / (2 * CLK_NS);
  localparam int TRANSFER_PAUSE_NS = 30000;
  localparam int TRANSFER_PAUSE_CYC = (TRANSFER_PAUSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int TIMER_W = 11;
  localparam logic [TIMER_W-1:0] MONO_LOAD = MONOFLOP_CYC[TIMER_W-1:0];
  localparam logic [TIMER_W-1:0] HALF_LOAD = SCLK_HALF_CYC[TIMER_W-1:0];
  localparam logic [TIMER_W-1:0] PAUSE_LOAD = TRANSFER_PAUSE_CYC[TIMER_W-1:0];

  // ==========================================================
  // Output codes
  typedef enum logic [1:0] {
    CODE_GRAY = 2'h0,
    CODE_GRAY_EXCESS = 2'h1,
    CODE_BINARY = 2'h2,
    CODE_BCD = 2'h3
  } ssienc_code_t;

  // ==========================================================
  // Controller registers
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_CTRL_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] REG_DATA_OFS = 4'h8;
  localparam int CTRL_START_BIT = 0;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_DONE_BIT = 1;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_WAIT_HIGH = 5'h02,
    ST_LOW = 5'h04,
    ST_HIGH = 5'h08,
    ST_PAUSE = 5'h10
  } ssienc_state_t;

endpackage : ssienc_pkg

/* File: hdl/ssienc_if.sv */
interface ssienc_if;
  logic sclk;
  logic sdata;

  modport encoder (
    input sclk,
    output sdata
  );

  modport controller (
    output sclk,
    input sdata
  );
endinterface : ssienc_if

/* File: hdl/ssienc_encoder.sv */
// Operation
// (R01) No clock: register follows shaft position
// (R02) Falling edge retriggers monoflop, selects shift
// (R03) Burst start captures and holds angle
// (R04) Controller clock period below monoflop timeout
// (R05) Controller sends fixed burst, then pause
// (R06) First rising edge drives MSB
// (R07) Later rising edges shift lower bits
// (R08) Alarm bit follows the LSB
// (R09) After data, line low until timeout
// (R10) Controller waits for data high again
// (R11) Continued clocking recirculates stored word
// (R12) Fixed clock count; interruption anywhere accepted
// (R13) Controller rate at most 1.5 Mbit/s
// (R14) Gray code: one bit per step
// (R15) Non power-of-two: centred Gray slice
// (R16) Binary: bit x weighs two to x
// (R17) BCD: 8-4-2-1 decades, no 10-15
// (R18) Clockwise ascending; switchover input reverses
// (R19) Latch input freezes output data
// (R20) Gray from binary by neighbour XOR
// (R21) Gray excess adds centring offset first
module ssienc_encoder
  import ssienc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Serial link
  ssienc_if.encoder link,
  // Shaft position, same clock domain
  input wire logic [POS_W-1:0] pos,
  // Pins
  input wire logic dir_switch,
  input wire logic latch,
  input wire logic alarm,
  input wire logic [1:0] code_sel,
  // Status
  output logic shift_mode,
  output logic [WORD_W-1:0] position_word
);

  // ==========================================================
  // Code conversion
  function automatic logic [WORD_W-1:0] ssienc_gray(input logic [POS_W-1:0] b);
    return WORD_W'(b ^ (b >> 1)); // R20 R14
  endfunction : ssienc_gray

  function automatic logic [WORD_W-1:0] ssienc_to_bcd(input logic [POS_W-1:0] b);
    logic [WORD_W-1:0] d;
    d = '0;
    for (int i = POS_W - 1; i >= 0; i--) begin
      for (int k = 0; k < WORD_W / 4; k++) begin
        // Add three before the shift keeps each decade below ten
        if (d[4*k+:4] > 4'h4) begin
          d[4*k+:4] = d[4*k+:4] + 4'h3; // R17
        end
      end
      d = {d[WORD_W-2:0], b[i]};
    end
    return d;
  endfunction : ssienc_to_bcd

  function automatic logic [WORD_W-1:0] ssienc_encode(
    input logic [POS_W-1:0] p_in,
    input logic rev,
    input logic [1:0] sel
  );
    logic [POS_W-1:0] p;
    logic [WORD_W-1:0] w;
    p = p_in;
    if (rev && (p_in != '0)) begin
      p = RES_POS - p_in; // R18
    end
    case (sel)
      CODE_GRAY: w = ssienc_gray(p); // R14
      CODE_GRAY_EXCESS: w = ssienc_gray(p + EXCESS_POS); // R21 R15
      CODE_BINARY: w = WORD_W'(p); // R16
      CODE_BCD: w = ssienc_to_bcd(p); // R17
      default: w = WORD_W'(p);
    endcase
    return w;
  endfunction : ssienc_encode

  // ==========================================================
  // Synchronisers
  logic sclk_s1_reg;
  logic sclk_s2_reg;
  logic sclk_s3_reg;
  logic [4:0] pin_s1_reg;
  logic [4:0] pin_s2_reg;
  logic sclk_fall;
  logic sclk_rise;
  logic dir_sync;
  logic latch_sync;
  logic alarm_sync;
  logic [1:0] code_sync;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sclk_s1_reg <= 1'b1;
      sclk_s2_reg <= 1'b1;
      sclk_s3_reg <= 1'b1;
    end else begin
      sclk_s1_reg <= link.sclk;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_s3_reg <= sclk_s2_reg;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pin_s1_reg <= 5'h00;
      pin_s2_reg <= 5'h00;
    end else begin
      pin_s1_reg <= {dir_switch, latch, alarm, code_sel};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  assign sclk_fall = sclk_s3_reg & ~sclk_s2_reg;
  assign sclk_rise = ~sclk_s3_reg & sclk_s2_reg;
  assign dir_sync = pin_s2_reg[4];
  assign latch_sync = pin_s2_reg[3];
  assign alarm_sync = pin_s2_reg[2];
  assign code_sync = pin_s2_reg[1:0];

  // ==========================================================
  // Retriggerable monoflop
  logic [TIMER_W-1:0] mono_cnt_reg;
  logic mono_active;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mono_cnt_reg <= '0;
    end else if (sclk_fall) begin
      mono_cnt_reg <= MONO_LOAD; // R02
    end else if (mono_cnt_reg != '0) begin
      mono_cnt_reg <= mono_cnt_reg - 1'b1;
    end
  end

  assign mono_active = (mono_cnt_reg != '0);
  assign shift_mode = mono_active;

  // ==========================================================
  // Load/shift register
  logic [FRAME_BITS-1:0] frame_reg;
  logic [CNT_W-1:0] bit_cnt_reg;
  logic ring_serial_out;
  logic ring_serial_in;

  assign ring_serial_out = frame_reg[FRAME_BITS-1];
  // Output folded back into the input keeps the stored word for repeat reads
  assign ring_serial_in = ring_serial_out; // R11

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      frame_reg <= '0;
    end else if (!mono_active && !sclk_fall) begin
      // Latch stops the free-running load, not the serial transfer
      if (!latch_sync) begin // R19
        frame_reg <= {ssienc_encode(pos, dir_sync, code_sync), alarm_sync}; // R01 R08
      end
    end else if (sclk_rise && (bit_cnt_reg < FRAME_CNT)) begin
      frame_reg <= {frame_reg[FRAME_BITS-2:0], ring_serial_in}; // R03 R07 R11
    end
  end

  // Counts bits sent; one extra low slot closes each frame
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bit_cnt_reg <= '0;
    end else if (!mono_active) begin
      bit_cnt_reg <= '0; // R12
    end else if (sclk_rise) begin
      if (bit_cnt_reg == FRAME_CNT) begin
        bit_cnt_reg <= '0; // R11
      end else begin
        bit_cnt_reg <= bit_cnt_reg + 1'b1;
      end
    end
  end

  // ==========================================================
  // Serial data output
  logic sdata_reg;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sdata_reg <= 1'b1;
    end else if (!mono_active) begin
      sdata_reg <= 1'b1; // R09
    end else if (sclk_rise) begin
      if (bit_cnt_reg < FRAME_CNT) begin
        sdata_reg <= ring_serial_out; // R06 R07 R08
      end else begin
        sdata_reg <= 1'b0; // R09
      end
    end
  end

  assign link.sdata = sdata_reg;

  // ==========================================================
  // Parallel view of the held word
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      position_word <= '0;
    end else if (!mono_active) begin
      position_word <= frame_reg[FRAME_BITS-1:1];
    end
  end

endmodule : ssienc_encoder

/* File: hdl/ssienc_controller.sv */
module ssienc_controller
  import ssienc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Serial link
  ssienc_if.controller link,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  // ==========================================================
  // Data line synchroniser
  logic sdata_s1_reg;
  logic sdata_s2_reg;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sdata_s1_reg <= 1'b0;
      sdata_s2_reg <= 1'b0;
    end else begin
      sdata_s1_reg <= link.sdata;
      sdata_s2_reg <= sdata_s1_reg;
    end
  end

  // ==========================================================
  // Bus slave: one wait cycle per access
  logic ack_reg;
  logic acc_wr;
  logic acc_rd;
  logic start_reg;
  logic done_reg;
  logic [FRAME_BITS-1:0] data_reg;
  ssienc_state_t state_reg;
  logic busy;
  logic frame_end;

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign acc_wr = avs_write & ack_reg;
  assign acc_rd = avs_read & ~ack_reg;
  assign busy = (state_reg != ST_IDLE);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      avs_readdata <= '0;
    end else if (acc_rd) begin
      case (avs_address)
        REG_STATUS_OFS: avs_readdata <= {30'h0, done_reg, busy};
        REG_DATA_OFS: avs_readdata <= 32'(data_reg);
        default: avs_readdata <= '0;
      endcase
    end
  end

  // Start request waits while a transfer runs
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      start_reg <= 1'b0;
    end else if (acc_wr && (avs_address == REG_CTRL_OFS) && avs_writedata[CTRL_START_BIT]) begin
      start_reg <= 1'b1;
    end else if (state_reg == ST_IDLE) begin
      start_reg <= 1'b0;
    end
  end

  // Done is sticky; completion wins over a clear in the same cycle
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      done_reg <= 1'b0;
    end else if (frame_end) begin
      done_reg <= 1'b1;
    end else if (acc_wr && (avs_address == REG_STATUS_OFS) && avs_writedata[STATUS_DONE_BIT]) begin
      done_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Clock burst sequencer
  logic [TIMER_W-1:0] timer_reg;
  logic [CNT_W-1:0] rise_cnt_reg;
  logic [FRAME_BITS-1:0] rx_reg;
  logic sclk_reg;
  logic timer_zero;

  assign timer_zero = (timer_reg == '0);
  assign frame_end = (state_reg == ST_HIGH) && timer_zero && (rise_cnt_reg == FRAME_CNT);
  assign link.sclk = sclk_reg;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      timer_reg <= '0;
      sclk_reg <= 1'b1;
      rise_cnt_reg <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start_reg) begin
            state_reg <= ST_WAIT_HIGH;
          end
        end
        ST_WAIT_HIGH: begin
          if (sdata_s2_reg) begin // R10
            state_reg <= ST_LOW;
            sclk_reg <= 1'b0;
            timer_reg <= HALF_LOAD - 1'b1; // R13 R04
            rise_cnt_reg <= '0;
          end
        end
        ST_LOW: begin
          if (timer_zero) begin
            state_reg <= ST_HIGH;
            sclk_reg <= 1'b1;
            timer_reg <= HALF_LOAD - 1'b1;
          end else begin
            timer_reg <= timer_reg - 1'b1;
          end
        end
        ST_HIGH: begin
          if (!timer_zero) begin
            timer_reg <= timer_reg - 1'b1;
          end else if (rise_cnt_reg == FRAME_CNT) begin
            state_reg <= ST_PAUSE; // R05 R12
            timer_reg <= PAUSE_LOAD - 1'b1;
          end else begin
            state_reg <= ST_LOW;
            sclk_reg <= 1'b0;
            timer_reg <= HALF_LOAD - 1'b1;
            rise_cnt_reg <= rise_cnt_reg + 1'b1;
          end
        end
        ST_PAUSE: begin
          if (timer_zero) begin
            state_reg <= ST_IDLE; // R05
          end else begin
            timer_reg <= timer_reg - 1'b1;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          sclk_reg <= 1'b1;
        end
      endcase
    end
  end

  // Bit sampled just before each falling edge after the first, MSB first
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rx_reg <= '0;
    end else if ((state_reg == ST_HIGH) && timer_zero && (rise_cnt_reg != FRAME_CNT)) begin
      rx_reg <= {rx_reg[FRAME_BITS-2:0], sdata_s2_reg};
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      data_reg <= '0;
    end else if (frame_end) begin
      data_reg <= rx_reg;
    end
  end

endmodule : ssienc_controller

/* File: verification/ssienc_link_monitor.sv */
module ssienc_link_monitor (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Serial link
  input wire logic sclk,
  input wire logic sdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Edge history; counters saturate so a long idle never wraps
  logic sclk_q;
  logic fall_ev;
  logic rise_ev;
  logic [10:0] since_fall;
  logic [10:0] high_cnt;
  logic [4:0] rise_cnt;

  assign fall_ev = sclk_q & ~sclk;
  assign rise_ev = ~sclk_q & sclk;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sclk_q <= 1'b1;
    end else begin
      sclk_q <= sclk;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      since_fall <= 11'h7ff;
    end else if (fall_ev) begin
      since_fall <= 11'h001;
    end else if (since_fall != 11'h7ff) begin
      since_fall <= since_fall + 11'h001;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      high_cnt <= 11'h7ff;
    end else if (!sclk) begin
      high_cnt <= 11'h000;
    end else if (high_cnt != 11'h7ff) begin
      high_cnt <= high_cnt + 11'h001;
    end
  end

  // Rise count restarts once the clock has idled well past a half period
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rise_cnt <= 5'h00;
    end else if (high_cnt > 11'h064) begin
      rise_cnt <= 5'h00;
    end else if (rise_ev && rise_cnt != 5'h1f) begin
      rise_cnt <= rise_cnt + 5'h01;
    end
  end

  // ==========================================================
  // Link checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_bit_settle;
    ##8 $stable(sdata) [*8];
  endsequence

  sequence s_end_low;
    ##8 (!sdata) [*8];
  endsequence

  a_low_half_len: assert property ($fell(sclk) |-> (!sclk) [*8])
    else $error("serial clock low half too short");
  a_low_half_end: assert property ($fell(sclk) |-> ##[1:40] sclk)
    else $error("serial clock low half too long");
  a_high_half_len: assert property ($rose(sclk) |-> sclk [*8])
    else $error("serial clock high half too short");
  a_rate_cap: assert property (fall_ev && since_fall != 11'h7ff |-> since_fall >= 11'h022)
    else $error("serial clock period below minimum");
  a_pause_len: assert property (fall_ev |-> high_cnt <= 11'h014 || high_cnt >= 11'h5dc)
    else $error("pause between frames too short");
  a_burst_count: assert property (fall_ev |-> rise_cnt <= 5'h11)
    else $error("too many clock periods in one frame");
  a_start_idle: assert property (fall_ev && high_cnt > 11'h064 |-> sdata)
    else $error("frame started while data line low");
  a_bit_settle: assert property ($rose(sclk) |-> s_bit_settle)
    else $error("data bit not stable within high half");
  a_end_low: assert property (rise_ev && rise_cnt == 5'h11 |-> s_end_low)
    else $error("data line not low after last bit");
  a_timeout_high: assert property ($rose(sdata) |->
    since_fall <= 11'h028 || (since_fall >= 11'h3de && since_fall <= 11'h3fc))
    else $error("data line returned high at wrong time");
  a_idle_high: assert property (since_fall >= 11'h44c |-> sdata)
    else $error("data line low while link idle");
endmodule : ssienc_link_monitor

/* File: verification/ssienc_tb_top.sv */
module ssienc_tb_top
  import ssienc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk;
  logic rstn;
  logic [POS_W-1:0] pos;
  logic dir_switch;
  logic latch;
  logic alarm;
  logic [1:0] code_sel;
  logic shift_mode;
  logic [WORD_W-1:0] position_word;
  logic [ADDR_W-1:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  int mismatches;
  int checks;

  ssienc_if link_if();

  ssienc_encoder ssienc_encoder_i (.sys_clk(sys_clk), .rstn(rstn), .link(link_if), .pos(pos),
    .dir_switch(dir_switch), .latch(latch), .alarm(alarm), .code_sel(code_sel),
    .shift_mode(shift_mode), .position_word(position_word));
  ssienc_controller ssienc_controller_i (.sys_clk(sys_clk), .rstn(rstn), .link(link_if),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  ssienc_link_monitor ssienc_link_monitor_i (.sys_clk(sys_clk), .rstn(rstn),
    .sclk(link_if.sclk), .sdata(link_if.sdata));

  // ==========================================================
  // Shared tasks
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask : bus_rd

  // Expected word, worked out independently of the design
  function automatic logic [15:0] enc(input logic [1:0] c, input logic [11:0] p, input logic rev);
    logic [11:0] b;
    logic [11:0] e;
    b = (rev && p != 12'h000) ? RES_POS - p : p;
    e = b + EXCESS_POS;
    case (c)
      2'h0: enc = {4'h0, b ^ (b >> 1)};
      2'h1: enc = {4'h0, e ^ (e >> 1)};
      2'h2: enc = {4'h0, b};
      default: enc = {4'h0, 4'(b / 12'h064), 4'(b / 12'h00a % 12'h00a), 4'(b % 12'h00a)};
    endcase
  endfunction : enc

  task automatic set_inputs(input logic [1:0] c, input logic [11:0] p, input logic rev, input logic al);
    @(posedge sys_clk);
    code_sel <= c;
    pos <= p;
    dir_switch <= rev;
    alarm <= al;
    repeat (10) @(posedge sys_clk);
  endtask : set_inputs

  // One start, poll for done, fetch data, clear done
  task automatic do_frame(output logic [31:0] d);
    logic [31:0] st;
    int n;
    st = 32'h0;
    n = 0;
    bus_wr(REG_CTRL_OFS, 32'h0000_0001);
    repeat (100) @(posedge sys_clk);
    check("shift_mode busy", 32'h1, {31'h0, shift_mode});
    bus_rd(REG_STATUS_OFS, st);
    check("busy in frame", 32'h1, {31'h0, st[STATUS_BUSY_BIT]});
    while (st[STATUS_DONE_BIT] !== 1'b1 && n < 400) begin
      repeat (20) @(posedge sys_clk);
      bus_rd(REG_STATUS_OFS, st);
      n++;
    end
    check("done", 32'h1, {31'h0, st[STATUS_DONE_BIT]});
    // Done comes before the monoflop and the pause run out; wait for both
    repeat (TRANSFER_PAUSE_CYC + 20) @(posedge sys_clk);
    check("shift_mode idle", 32'h0, {31'h0, shift_mode});
    bus_rd(REG_STATUS_OFS, st);
    check("busy after pause", 32'h0, {31'h0, st[STATUS_BUSY_BIT]});
    bus_rd(REG_DATA_OFS, d);
    bus_wr(REG_STATUS_OFS, 32'h0000_0002);
  endtask : do_frame

  // ==========================================================
  // Scenarios
  task automatic test_reset();
    logic [31:0] d;
    bus_rd(REG_STATUS_OFS, d);
    check("status after reset", 32'h0, d);
    bus_wr(4'hc, 32'hffff_ffff);
    bus_rd(4'hc, d);
    check("unmapped read", 32'h0, d);
    bus_rd(REG_STATUS_OFS, d);
    check("status after unmapped write", 32'h0, d);
  endtask : test_reset

  task automatic test_codes();
    logic [11:0] pv [2];
    logic [31:0] d;
    pv = '{12'h000, 12'h167};
    for (int c = 0; c < 4; c++) begin
      for (int i = 0; i < 2; i++) begin
        set_inputs(2'(c), pv[i], 1'b0, pv[i][0]);
        check("parallel word", {16'h0, enc(2'(c), pv[i], 1'b0)}, {16'h0, position_word});
        do_frame(d);
        check("frame", {15'h0, enc(2'(c), pv[i], 1'b0), pv[i][0]}, d);
      end
    end
  endtask : test_codes

  task automatic test_direction();
    logic [31:0] d;
    set_inputs(2'h2, 12'h001, 1'b1, 1'b0);
    do_frame(d);
    check("reversed frame", {15'h0, enc(2'h2, 12'h001, 1'b1), 1'b0}, d);
  endtask : test_direction

  task automatic test_latch();
    logic [31:0] d;
    set_inputs(2'h2, 12'h064, 1'b0, 1'b1);
    latch <= 1'b1;
    // Latch crosses a two-stage synchroniser; position is not synchronised
    repeat (5) @(posedge sys_clk);
    set_inputs(2'h2, 12'h0c8, 1'b0, 1'b1);
    check("frozen word", 32'h0000_0064, {16'h0, position_word});
    do_frame(d);
    check("frozen frame", 32'h0000_00c9, d);
    latch <= 1'b0;
    repeat (10) @(posedge sys_clk);
    check("released word", 32'h0000_00c8, {16'h0, position_word});
  endtask : test_latch

  // ==========================================================
  // Clock, watchdog and main sequence
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (60000) @(posedge sys_clk);
    mismatches = mismatches + 1;
    finish_test();
  end

  initial begin
    rstn = 1'b0;
    pos = 12'h000;
    dir_switch = 1'b0;
    latch = 1'b0;
    alarm = 1'b0;
    code_sel = 2'h0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    mismatches = 0;
    checks = 0;
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    test_reset();
    test_codes();
    test_direction();
    test_latch();
    finish_test();
  end
endmodule : ssienc_tb_top
